//--- frame_codec_pkg.sv
// Constants, register map and shared helpers for the fixed-frame host codec.
// Assumes a byte-wide transport on the same clock carries frames to and from the radar unit.
package frame_codec_pkg;

  localparam logic [7:0]  START_SYM      = 8'h7e;
  localparam logic [7:0]  END_SYM        = 8'h7f;
  localparam logic [7:0]  TYPE_USER      = 8'h01;
  localparam logic [7:0]  TYPE_SEND_REQ  = 8'h02;
  localparam logic [7:0]  TYPE_RELAY     = 8'h03;
  localparam logic [7:0]  TYPE_DISTANCE  = 8'h16;
  localparam logic [7:0]  LEN_USER       = 8'h0f;
  localparam logic [7:0]  LEN_SEND_REQ   = 8'h05;
  localparam logic [7:0]  LEN_RELAY      = 8'h09;
  localparam logic [7:0]  LEN_DISTANCE   = 8'h2f;
  localparam logic [7:0]  FRAME_LEN_RST  = 8'h2f;
  localparam logic [15:0] CRC_INIT       = 16'h0000;
  localparam logic [15:0] CRC_POLY_REFL  = 16'ha001;
  localparam int          RX_KEEP        = 12;
  localparam logic [7:0]  RX_KEEP_FIRST  = 8'h04;

  // Register offsets (byte addresses, one word each)
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_FRAME_LEN  = 8'h04;
  localparam logic [7:0]  REG_ADDRS      = 8'h08;
  localparam logic [7:0]  REG_USER_HI    = 8'h0c;
  localparam logic [7:0]  REG_USER_LO    = 8'h10;
  localparam logic [7:0]  REG_RELAY      = 8'h14;
  localparam logic [7:0]  REG_STATUS     = 8'h18;
  localparam logic [7:0]  REG_RX_INFO    = 8'h1c;
  localparam logic [7:0]  REG_RX_W0      = 8'h20;
  localparam logic [7:0]  REG_RX_W1      = 8'h24;
  localparam logic [7:0]  REG_RX_W2      = 8'h28;

  // Field positions
  localparam int          CTRL_GO_USER   = 0;
  localparam int          CTRL_GO_RELAY  = 1;
  localparam int          CTRL_HANDSHAKE = 2;
  localparam int          ST_BUSY        = 0;
  localparam int          ST_CREDIT      = 1;
  localparam int          ST_CRC_ERR     = 2;
  localparam int          ST_FRAME_ERR   = 3;
  localparam int          ST_RX_NEW      = 4;
  localparam int          ST_PENDING     = 5;

  typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SEND = 1'b1} tx_state_t;

  // Reflected CRC-16, polynomial x^16+x^15+x^2+1
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
    end
    return c;
  endfunction

  // Content length per known type; zero for types this codec does not check
  function automatic logic [7:0] content_len(input logic [7:0] t);
    if (t == TYPE_USER) return LEN_USER;
    else if (t == TYPE_SEND_REQ) return LEN_SEND_REQ;
    else if (t == TYPE_RELAY) return LEN_RELAY;
    else if (t == TYPE_DISTANCE) return LEN_DISTANCE;
    else return 8'h00;
  endfunction

endpackage

//--- fixed_frame_host.sv
// Host-side codec for the fixed frame protocol: builds outgoing user-data and output
// switching frames, parses incoming frames, checks CRC and tracks send requests.
// Assumes an APB master for control and a same-clock byte transport (valid/ready out,
// valid-only in; the host never stalls reception).
//
// Notes on behaviour
// - Fixed-length frames, first byte 0x7e
// - End symbol 0x7f follows the CRC
// - Second byte is the type code
// - CRC covers type and data only
// - CRC-16 with x^16+x^15+x^2+1
// - Multi-byte fields sent MSB first
// - Signed fields are two's complement
// - Host reads blocks of frame length
// - Host pads outgoing frames to length
// - User data: address, 8 bytes, 15 total
// - One host frame per send request
// - Switch command: address, select, state masks
// - Host connects to port 3046 by default; here a same-clock byte transport carries the frames instead
// - Address: station, group, bit0 zero
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/10ps
module fixed_frame_host
  import frame_codec_pkg::*;
(
  input  wire logic        clk,      // 40 MHz system clock
  input  wire logic        nrst,     // Asynchronous reset, active low
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB enable
  input  wire logic        pwrite,   // APB write
  input  wire logic [7:0]  paddr,    // APB byte address
  input  wire logic [31:0] pwdata,   // APB write data
  output logic      [31:0] prdata,   // APB read data
  output logic             pready,   // APB ready
  output logic             pslverr,  // APB error on unmapped address
  output logic      [7:0]  tx_data,  // Outgoing stream byte
  output logic             tx_valid, // Outgoing byte valid
  input  wire logic        tx_ready, // Transport takes byte
  input  wire logic [7:0]  rx_data,  // Incoming stream byte
  input  wire logic        rx_valid  // Incoming byte valid
);
  import frame_codec_pkg::*;

  logic        handshake_en;
  logic [7:0]  frame_len;
  logic [15:0] src_addr;
  logic [15:0] dst_addr;
  logic [63:0] user_bytes;
  logic [7:0]  sel_mask;
  logic [7:0]  state_mask;
  logic        pend_user;
  logic        pend_relay;
  logic        credit;
  logic        crc_err;
  logic        frame_err;
  logic        rx_new;
  tx_state_t   tx_state;
  logic [7:0]  tx_type;
  logic [7:0]  tx_idx;
  logic [15:0] tx_crc;
  logic [7:0]  rx_idx;
  logic [7:0]  rx_type;
  logic [15:0] rx_crc;
  logic [15:0] rx_crc_field;
  logic        rx_start_ok;
  logic        rx_end_ok;
  logic [7:0]  last_type;
  logic [7:0]  rx_buf [RX_KEEP];
  logic [7:0]  rx_hold [RX_KEEP];

  logic        apb_write;
  logic        apb_read;
  logic        start_tx;
  logic        tx_take;
  logic [15:0] next_tx_crc;
  logic [7:0]  tx_clen;
  logic [7:0]  next_tx_data;
  logic [7:0]  rx_t;
  logic [7:0]  rx_clen;
  logic [15:0] next_rx_crc;
  logic        rx_last;
  logic        end_now;
  logic        rx_good;
  logic        rx_bad_crc;
  logic        rx_bad_frame;
  logic [7:0]  tx_last_idx;
  logic [7:0]  rx_field_idx;

  assign apb_write = psel & penable & pready & pwrite;
  assign apb_read  = psel & penable & ~pready & ~pwrite;

  // APB: one wait state, then ready for a single cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & (paddr > REG_RX_W2 || paddr[1:0] != 2'b00);
      if (apb_read) begin
        if (paddr == REG_CTRL) prdata <= {29'h0, handshake_en, pend_relay, pend_user};
        else if (paddr == REG_FRAME_LEN) prdata <= {24'h0, frame_len};
        else if (paddr == REG_ADDRS) prdata <= {dst_addr, src_addr};
        else if (paddr == REG_USER_HI) prdata <= user_bytes[63:32];
        else if (paddr == REG_USER_LO) prdata <= user_bytes[31:0];
        else if (paddr == REG_RELAY) prdata <= {16'h0, state_mask, sel_mask};
        else if (paddr == REG_STATUS) prdata <= {26'h0, pend_user | pend_relay, rx_new, frame_err, crc_err,
                                                 credit, tx_state == TX_SEND};
        else if (paddr == REG_RX_INFO) prdata <= {24'h0, last_type};
        else if (paddr == REG_RX_W0) prdata <= {rx_hold[0], rx_hold[1], rx_hold[2], rx_hold[3]};
        else if (paddr == REG_RX_W1) prdata <= {rx_hold[4], rx_hold[5], rx_hold[6], rx_hold[7]};
        else if (paddr == REG_RX_W2) prdata <= {rx_hold[8], rx_hold[9], rx_hold[10], rx_hold[11]};
        else prdata <= 32'h0000_0000;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      handshake_en <= 1'b1;
      frame_len    <= FRAME_LEN_RST;
      src_addr     <= 16'h0000;
      dst_addr     <= 16'h0000;
      user_bytes   <= 64'h0;
      sel_mask     <= 8'h00;
      state_mask   <= 8'h00;
    end else if (apb_write) begin
      if (paddr == REG_CTRL) handshake_en <= pwdata[CTRL_HANDSHAKE];
      else if (paddr == REG_FRAME_LEN) frame_len <= pwdata[7:0];
      else if (paddr == REG_ADDRS) begin
        src_addr <= {pwdata[15:1], 1'b0};
        dst_addr <= {pwdata[31:17], 1'b0};
      end else if (paddr == REG_USER_HI) user_bytes[63:32] <= pwdata;
      else if (paddr == REG_USER_LO) user_bytes[31:0] <= pwdata;
      else if (paddr == REG_RELAY) begin
        sel_mask   <= pwdata[7:0];
        state_mask <= pwdata[15:8];
      end
    end
  end

  // Pending send orders; a new order while one waits is ignored
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_user  <= 1'b0;
      pend_relay <= 1'b0;
    end else if (start_tx) begin
      pend_user  <= 1'b0;
      pend_relay <= 1'b0;
    end else if (apb_write && paddr == REG_CTRL && !pend_user && !pend_relay) begin
      pend_user  <= pwdata[CTRL_GO_USER];
      pend_relay <= pwdata[CTRL_GO_RELAY] & ~pwdata[CTRL_GO_USER];
    end
  end

  // Credit from a received send request; a new request beats consumption
  assign start_tx = (tx_state == TX_IDLE) && (pend_user || pend_relay) && (credit || !handshake_en);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) credit <= 1'b0;
    else if (rx_good && rx_type == TYPE_SEND_REQ) credit <= 1'b1;
    else if (start_tx) credit <= 1'b0;
  end

  // Transmit byte builder
  function automatic logic [7:0] tx_byte(input logic [7:0] t, input logic [7:0] i, input logic [15:0] c);
    logic [7:0] cl;
    cl = content_len(t);
    if (i == 8'h00) return START_SYM;
    else if (i == 8'h01) return t;
    else if (i == 8'h02) return (t == TYPE_USER) ? src_addr[15:8] : dst_addr[15:8];
    else if (i == 8'h03) return (t == TYPE_USER) ? src_addr[7:0] : dst_addr[7:0];
    else if (i == cl - 8'h03) return c[15:8];
    else if (i == cl - 8'h02) return c[7:0];
    else if (i == cl - 8'h01) return END_SYM;
    else if (i >= cl) return 8'h00;
    else if (t == TYPE_RELAY) return (i == 8'h04) ? sel_mask : state_mask;
    else return user_bytes[8'd63 - 8'((i - 8'h04) * 8'h08) -: 8];
  endfunction

  assign tx_take     = (tx_state == TX_SEND) && tx_ready;
  assign tx_clen     = content_len(tx_type);
  assign tx_last_idx = (frame_len > tx_clen) ? frame_len - 8'h01 : tx_clen - 8'h01;
  assign next_tx_crc = (tx_idx >= 8'h01 && tx_idx <= tx_clen - 8'h04) ? crc_byte(tx_crc, tx_data) : tx_crc;
  assign next_tx_data = tx_byte(tx_type, tx_idx + 8'h01, next_tx_crc);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_state <= TX_IDLE;
      tx_type  <= 8'h00;
      tx_idx   <= 8'h00;
      tx_crc   <= CRC_INIT;
      tx_data  <= 8'h00;
      tx_valid <= 1'b0;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (start_tx) begin
            tx_state <= TX_SEND;
            tx_type  <= pend_user ? TYPE_USER : TYPE_RELAY;
            tx_idx   <= 8'h00;
            tx_crc   <= CRC_INIT;
            tx_data  <= START_SYM;
            tx_valid <= 1'b1;
          end
        end
        TX_SEND: begin
          if (tx_take) begin
            tx_crc <= next_tx_crc;
            if (tx_idx == tx_last_idx) begin
              tx_state <= TX_IDLE;
              tx_valid <= 1'b0;
              tx_data  <= 8'h00;
            end else begin
              tx_idx  <= tx_idx + 8'h01;
              tx_data <= next_tx_data;
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // Receive: fixed blocks of frame_len bytes
  assign rx_t         = (rx_idx == 8'h01) ? rx_data : rx_type;
  assign rx_clen      = content_len(rx_t);
  assign next_rx_crc  = (rx_idx >= 8'h01 && rx_idx <= rx_clen - 8'h04) ? crc_byte(rx_crc, rx_data) : rx_crc;
  assign rx_last      = rx_valid && (rx_idx == frame_len - 8'h01 || frame_len == 8'h00);
  assign end_now      = (rx_clen != 8'h00) && (rx_idx == rx_clen - 8'h01) && (rx_data == END_SYM);
  assign rx_bad_frame = rx_last && (!rx_start_ok || (rx_clen != 8'h00 && !(rx_end_ok || end_now)));
  assign rx_bad_crc   = rx_last && rx_clen != 8'h00 && rx_crc != rx_crc_field;
  assign rx_good      = rx_last && !rx_bad_frame && !rx_bad_crc;
  assign rx_field_idx = rx_idx - RX_KEEP_FIRST;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_idx       <= 8'h00;
      rx_type      <= 8'h00;
      rx_crc       <= CRC_INIT;
      rx_crc_field <= 16'h0000;
      rx_start_ok  <= 1'b0;
      rx_end_ok    <= 1'b0;
      last_type    <= 8'h00;
      for (int i = 0; i < RX_KEEP; i++) begin
        rx_buf[i]  <= 8'h00;
        rx_hold[i] <= 8'h00;
      end
    end else if (rx_valid) begin
      rx_crc <= next_rx_crc;
      if (rx_idx == 8'h00) begin
        rx_start_ok <= (rx_data == START_SYM);
        rx_end_ok   <= 1'b0;
        rx_crc      <= CRC_INIT;
      end
      if (rx_idx == 8'h01) rx_type <= rx_data;
      if (rx_idx >= RX_KEEP_FIRST && rx_field_idx < 8'(RX_KEEP)) rx_buf[rx_field_idx[3:0]] <= rx_data;
      if (rx_clen != 8'h00 && rx_idx == rx_clen - 8'h03) rx_crc_field[15:8] <= rx_data;
      if (rx_clen != 8'h00 && rx_idx == rx_clen - 8'h02) rx_crc_field[7:0] <= rx_data;
      if (end_now) rx_end_ok <= 1'b1;
      if (rx_last) begin
        rx_idx <= 8'h00;
        if (rx_good) begin
          last_type <= rx_type;
          for (int i = 0; i < RX_KEEP; i++) begin
            rx_hold[i] <= rx_buf[i];
          end
        end
      end else begin
        rx_idx <= rx_idx + 8'h01;
      end
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      crc_err   <= 1'b0;
      frame_err <= 1'b0;
      rx_new    <= 1'b0;
    end else begin
      crc_err   <= rx_bad_crc | (crc_err & ~(apb_write && paddr == REG_STATUS && pwdata[ST_CRC_ERR]));
      frame_err <= rx_bad_frame | (frame_err & ~(apb_write && paddr == REG_STATUS && pwdata[ST_FRAME_ERR]));
      rx_new    <= (rx_good && rx_type != TYPE_SEND_REQ) |
                   (rx_new & ~(apb_write && paddr == REG_STATUS && pwdata[ST_RX_NEW]));
    end
  end

endmodule

//--- fixed_frame_host_sva.sv
// Checker for the host codec: APB answer timing and shape of outgoing frames.
// Assumes it is bound onto fixed_frame_host and sees only that module's ports.
`timescale 1ns/10ps
module frame_host_chk (
  input wire logic        clk,      // System clock
  input wire logic        nrst,     // Reset, active low
  input wire logic        psel,     // APB select
  input wire logic        penable,  // APB enable
  input wire logic        pwrite,   // APB write
  input wire logic [7:0]  paddr,    // APB address
  input wire logic [31:0] pwdata,   // APB write data
  input wire logic [31:0] prdata,   // APB read data
  input wire logic        pready,   // APB ready
  input wire logic        pslverr,  // APB error
  input wire logic [7:0]  tx_data,  // Outgoing byte
  input wire logic        tx_valid, // Outgoing byte valid
  input wire logic        tx_ready, // Byte taken
  input wire logic [7:0]  rx_data,  // Incoming byte
  input wire logic        rx_valid  // Incoming byte valid
);
  logic [7:0] idx;
  logic [7:0] ftype;
  logic [7:0] last;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) idx <= 8'h00;
    else if (!tx_valid) idx <= 8'h00;
    else if (tx_ready) idx <= idx + 8'h01;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) ftype <= 8'h00;
    else if (tx_valid && tx_ready && idx == 8'h01) ftype <= tx_data;
  end
  // End position is only trusted once the type byte has passed
  assign last = (ftype == 8'h01) ? 8'h0e : 8'h08;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_ready_walk: assert property (s_setup ##1 s_access |-> !pready ##1 (pready && psel && penable))
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_err_unmapped: assert property (pready && (paddr > 8'h28 || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (pready && paddr <= 8'h28 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  a_start_sym: assert property (tx_valid && idx == 8'h00 |-> tx_data == 8'h7e)
    else $error("frame does not open with start symbol");
  a_type_code: assert property (tx_valid && idx == 8'h01 |-> tx_data inside {8'h01, 8'h03})
    else $error("bad type byte");
  a_end_sym: assert property (tx_valid && idx == last |-> tx_data == 8'h7f)
    else $error("end symbol missing after checksum");
  a_pad_zero: assert property (tx_valid && idx > last |-> tx_data == 8'h00)
    else $error("padding byte not zero");
  a_byte_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("byte changed before taken");
endmodule
bind fixed_frame_host frame_host_chk u_chk (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid));

//--- radar_unit_model.sv
// Behavioural radar unit on the far side of the codec's byte stream.
// Assumes the codec's clock; the bench calls send() to inject frames.
`timescale 1ns/10ps
module radar_unit_model #(parameter int FRAME_LEN = 47) (
  input  wire logic       clk,      // System clock
  input  wire logic       nrst,     // Reset, active low
  input  wire logic [7:0] tx_data,  // Byte from host
  input  wire logic       tx_valid, // Host byte valid
  output logic            tx_ready, // Byte accepted
  output logic      [7:0] rx_data,  // Byte to host
  output logic            rx_valid, // Byte to host valid
  input  wire logic       slow      // Stall every other cycle
);
  logic [7:0]  fr[$];
  logic [7:0]  got[$];
  logic [7:0]  relay;
  logic [15:0] c;
  int          n;
  int          nframes;
  int          nbad;
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
  end
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] r;
    r = 16'h0000;
    foreach (b[i]) begin
      r ^= {8'h00, b[i]};
      repeat (8) r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
    end
    return r;
  endfunction
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_ready <= 1'b0;
      relay    <= 8'h00;
      nframes = 0;
      nbad = 0;
      fr = {};
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready) fr.push_back(tx_data);
      if (fr.size() == FRAME_LEN) begin
        got = fr;
        n = (fr[1] == 8'h01) ? 15 : 9;
        c = {fr[n-3], fr[n-2]};
        if (fr[0] == 8'h7e && fr[n-1] == 8'h7f && (c == 16'h0000 || c == crc16(fr[1:n-4]))) begin
          if (fr[1] == 8'h03) relay <= (relay & ~fr[4]) | (fr[4] & fr[5]);
          nframes++;
        end else nbad++;
        fr = {};
      end
    end
  end
  // Fault bit 0 spoils the checksum, bit 1 the end symbol
  task automatic send(input logic [7:0] b[$], input logic [1:0] fault);
    logic [15:0] k;
    k = crc16(b[1:$]) ^ {15'h0000, fault[0]};
    b.push_back(k[15:8]);
    b.push_back(k[7:0]);
    b.push_back(fault[1] ? 8'h00 : 8'h7f);
    while (b.size() < FRAME_LEN) b.push_back(8'h00);
    foreach (b[i]) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data  <= b[i];
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data  <= ~b[FRAME_LEN-1]; // Released line must not look like the last byte
  endtask
endmodule

//--- tb_top.sv
// Self-checking bench for the host codec against a behavioural radar unit.
// Assumes the package, codec, checker and unit model are compiled before it.
`timescale 1ns/10ps
module tb_top;
  import frame_codec_pkg::*;
  logic        clk, nrst, psel, penable, pwrite, slow, pready, pslverr, tx_valid, tx_ready, rx_valid, err;
  logic [7:0]  paddr, tx_data, rx_data, sel, st, rel;
  logic [31:0] pwdata, prdata, rd, w0, adr;
  logic [7:0]  q[$], d[$];
  int          fails, num_checks, seed, k, n0;
  fixed_frame_host dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid));
  radar_unit_model #(.FRAME_LEN(47)) u_dev (.clk(clk), .nrst(nrst), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .slow(slow));
  always #12.5 clk = ~clk;
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_frame(input logic [7:0] g[$], input logic [7:0] e[$]);
    logic bad;
    bad = (g.size() != e.size());
    for (int i = 0; i < g.size() && !bad; i++) bad = (g[i] !== e[i]);
    num_checks++;
    if (bad) begin
      fails++;
      $display("unexpected at %0t: frame bytes differ", $time);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= v;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Expected outgoing frame: start, content, checksum high first, end, zero fill
  task automatic build(input logic [7:0] b[$]);
    logic [15:0] c;
    c = u_dev.crc16(b);
    q = {8'h7e, b, c[15:8], c[7:0], 8'h7f};
    while (q.size() < 47) q.push_back(8'h00);
  endtask
  task automatic wait_frame();
    n0 = u_dev.nframes;
    for (int i = 0; i < 400 && u_dev.nframes == n0; i++) @(posedge clk);
    // One more edge so the unit's output state has settled
    @(posedge clk);
    if (u_dev.nframes == n0) begin
      fails++;
      $display("unexpected at %0t: no frame reached the unit", $time);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #500000;
    fails++;
    stop_test();
  end
  initial begin
    clk = 1'b0; nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; slow = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; seed = 11950; rel = 8'h00;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    apb(0, REG_CTRL, 0);
    chk_reg(rd, 32'h4, "ctrl reset");
    apb(0, REG_FRAME_LEN, 0);
    chk_reg(rd, 32'd47, "frame length reset");
    apb(0, REG_STATUS, 0);
    chk_reg(rd, 32'h0, "status reset");
    apb(0, 8'h2c, 0);
    chk_reg({31'h0, err}, 32'h1, "unmapped refused");
    apb(1, 8'h05, 0);
    chk_reg({31'h0, err}, 32'h1, "misaligned refused");
    $display("test 1 done");
    for (k = 0; k < 2; k++) begin
      adr = $random(seed) & 32'hfffefffe;
      w0 = $random(seed);
      apb(1, REG_ADDRS, adr);
      apb(1, REG_USER_HI, w0);
      apb(1, REG_USER_LO, ~w0);
      apb(1, REG_CTRL, 32'h5);
      repeat (30) @(posedge clk);
      chk_reg({31'h0, tx_valid}, 32'h0, "frame sent without send request");
      apb(0, REG_STATUS, 0);
      chk_reg(rd & 32'h23, 32'h20, "order waits for request");
      d = {8'h7e, 8'h02};
      u_dev.send(d, 2'b00);
      wait_frame();
      build({8'h01, adr[15:8], adr[7:0], w0[31:24], w0[23:16], w0[15:8], w0[7:0],
             ~w0[31:24], ~w0[23:16], ~w0[15:8], ~w0[7:0]});
      chk_frame(u_dev.got, q);
    end
    $display("test 2 done");
    apb(1, REG_CTRL, 32'h0);
    for (k = 0; k < 3; k++) begin
      slow <= k[0];
      {st, sel} = 16'($random(seed));
      apb(1, REG_RELAY, {16'h0, st, sel});
      apb(1, REG_CTRL, 32'h2);
      wait_frame();
      rel = (rel & ~sel) | (sel & st);
      build({8'h03, adr[31:24], adr[23:16], sel, st});
      chk_frame(u_dev.got, q);
      chk_reg({24'h0, u_dev.relay}, {24'h0, rel}, "output state");
    end
    $display("test 3 done");
    for (k = 0; k < 3; k++) begin
      d = {8'h7e, 8'h16};
      repeat (42) d.push_back(8'($random(seed)));
      u_dev.send(d, k[1:0]);
      repeat (3) @(posedge clk);
      apb(0, REG_STATUS, 0);
      chk_reg(rd & 32'h1c, (k == 0) ? 32'h10 : (k == 1) ? 32'h14 : 32'h1c, "receive status");
      if (k == 0) w0 = {d[8], d[9], d[10], d[11]};
      apb(0, REG_RX_W1, 0);
      chk_reg(rd, w0, "velocity word kept");
    end
    apb(0, REG_RX_INFO, 0);
    chk_reg(rd & 32'hff, 32'h16, "last type");
    apb(1, REG_STATUS, 32'h1c);
    apb(0, REG_STATUS, 0);
    chk_reg(rd & 32'h3f, 32'h0, "status cleared");
    $display("test 4 done");
    stop_test();
  end
endmodule
